// File: hw/dim_defs.svh
`ifndef DIM_DEFS_SVH
`define DIM_DEFS_SVH
// Register offsets (word index on the plain port).
`define DIM_OFS_FSEL1      8'h00
`define DIM_OFS_FSEL2_1    8'h08
`define DIM_OFS_POL1       8'h10
`define DIM_OFS_CTRL       8'h18
`define DIM_OFS_STATUS     8'h19
`define DIM_OFS_FUNC_LO    8'h1A
`define DIM_OFS_FUNC_HI    8'h1B
`define DIM_OFS_PRESET     8'h1C
// Function codes.
`define DIM_FN_CW          8'h00
`define DIM_FN_CCW         8'h01
`define DIM_FN_PRESET0     8'h02
`define DIM_FN_PRESET3     8'h05
`define DIM_FN_JOG         8'h06
`define DIM_FN_DCB         8'h07
`define DIM_FN_SET2        8'h08
`define DIM_FN_RAMP2       8'h09
`define DIM_FN_COAST       8'h0B
`define DIM_FN_EXTFLT      8'h0C
`define DIM_FN_USP         8'h0D
`define DIM_FN_LOCK        8'h0F
`define DIM_FN_AIN         8'h10
`define DIM_FN_FRST        8'h12
`define DIM_FN_PTC         8'h13
`define DIM_FN_STA         8'h14
`define DIM_FN_STP         8'h15
`define DIM_FN_FR          8'h16
`define DIM_FN_PID         8'h17
`define DIM_FN_INTEGRAL_CLEAR        8'h18
`define DIM_FN_UP          8'h1B
`define DIM_FN_DWN         8'h1C
`define DIM_FN_DWN0        8'h1D
`define DIM_FN_OPE         8'h1F
`define DIM_FN_ADD         8'h32
`define DIM_FN_FTM         8'h33
`define DIM_FN_RDY         8'h34
`define DIM_FN_SPSET       8'h35
`define DIM_FN_UNUSED      8'hFF
// Reset values of the selectors, terminal 1 to 5.
`define DIM_RST_FSEL1      8'h00
`define DIM_RST_FSEL2      8'h01
`define DIM_RST_FSEL3      8'h02
`define DIM_RST_FSEL4      8'h03
`define DIM_RST_FSEL5      8'h12
`define DIM_RST_POL        8'h00
`define DIM_POL_NC         8'h01
// Deceleration time default, in seconds.
`define DIM_DECEL_S        10
`endif

// File: hw/dim_pkg.sv
package dim_pkg;
    // Run state of the decoded command path.
    typedef enum logic [3:0] {
        DIM_ST_STOP  = 4'b0001,
        DIM_ST_RUN   = 4'b0010,
        DIM_ST_DECEL = 4'b0100,
        DIM_ST_COAST = 4'b1000
    } dim_state_t;

    // Decoded function levels handed to the drive core.
    typedef struct packed {
        logic       jog;
        logic       dc_braking;
        logic       second_set;
        logic       alt_ramp_select;
        logic       free_coast_inhibit;
        logic       outside_fault_trip;
        logic       power_on_start_guard;
        logic       parameter_lock;
        logic       analog_input_choose;
        logic       fault_reset;
        logic       thermistor_input;
        logic       three_wire_run_pulse;
        logic       three_wire_halt;
        logic       three_wire_dir;
        logic       closed_loop_enable;
        logic       integral_clear;
        logic       motor_pot_raise;
        logic       motor_pot_lower;
        logic       motor_pot_zero;
        logic       keypad_control_select;
        logic       freq_offset_add;
        logic       terminal_control_force;
        logic       fast_response;
        logic       second_bank_special;
    } dim_func_t;

    // Run command to the drive core.
    typedef struct packed {
        logic run;
        logic ccw;
        logic decel;
        logic coast;
    } dim_cmd_t;
endpackage

// File: hw/dim_mapper.sv
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "dim_defs.svh"
module dim_mapper #(
    parameter int NUM_IN = 5
) (
    input  wire logic            i_clk_sys,
    input  wire logic            i_rst,
    input  wire logic [4:0]      i_term,
    input  wire logic            i_keypad_stop,
    input  wire logic [7:0]      i_addr,
    input  wire logic [7:0]      i_wdata,
    input  wire logic            i_wr,
    input  wire logic            i_rd,
    output logic      [7:0]      o_rdata,
    output dim_pkg::dim_cmd_t    o_cmd,
    output dim_pkg::dim_func_t   o_func,
    output logic      [3:0]      o_preset_sel,
    output logic                 o_current_loop_only,
    output logic                 o_restart_sync,
    output logic                 o_restart_wait
);
    import dim_pkg::*;

    localparam int DECEL_S = `DIM_DECEL_S;

    logic [7:0]   fsel     [5];
    logic [7:0]   fsel2    [5];
    logic [7:0]   pol      [5];
    logic [7:0]   ctrl;
    logic [4:0]   sync1;
    logic [4:0]   sync2;
    dim_state_t   state;
    dim_state_t   next_state;
    logic         coast_prev;
    logic         wr_reject;

    // Code held by one terminal in the chosen parameter set. Every lookup
    // outside the read port goes through here, so the two sets can never be mixed up by index.
    function automatic logic [7:0] sel_code(input logic [2:0] idx,
                                            input logic       bank);
        logic [7:0] code;
        code = fsel[idx];
        if (bank) begin
            code = fsel2[idx];
        end
        return code;
    endfunction

    // Software may only store a code that no other terminal already holds.
    // The unused code is exempt, since any number of terminals may idle.
    function automatic logic code_taken(input logic [7:0] code,
                                        input logic [2:0] idx,
                                        input logic       bank);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < 5; k++) begin
            if (k != int'(idx) && code != `DIM_FN_UNUSED) begin
                if (sel_code(3'(k), bank) == code) begin
                    hit = 1'b1;
                end
            end
        end
        return hit;
    endfunction

    // Level of the function with the given code from the active set.
    // Refused duplicates guarantee at most one terminal can match.
    function automatic logic fn_on(input logic [7:0] code,
                                   input logic [4:0] act,
                                   input logic       bank);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < 5; k++) begin
            if (sel_code(3'(k), bank) == code && act[k]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // Register map, one byte per word index on the plain port:
    //   00 to 04  function selectors of terminals 1 to 5, first set.
    //   08 to 0C  the same selectors in the second set.
    //   10 to 14  polarity of terminals 1 to 5, bit 0 only.
    //   18        control: bit 0 picks the active set, bit 1 asks for
    //             speed synchronisation after a coast stop.
    //   19        status: refused-write flag in bit 7, run state below.
    //   1A        terminal levels after polarity, for diagnosis.
    //   1C        preset index as decoded from the terminals.
    // Every other index reads as zero; a write there only clears the refused-write flag.
    // The idle set may be rewritten while the motor runs; a set switch
    // acts on the next clock, so software should stop the drive first
    // when the two sets map the run inputs differently.
    // Register decode.
    wire [2:0] fs_idx   = 3'(i_addr - `DIM_OFS_FSEL1);
    wire [2:0] f2_idx   = 3'(i_addr - `DIM_OFS_FSEL2_1);
    wire [2:0] pl_idx   = 3'(i_addr - `DIM_OFS_POL1);
    wire       hit_fs   = i_addr >= `DIM_OFS_FSEL1 && fs_idx < 3'd5
                          && i_addr < `DIM_OFS_FSEL2_1;
    wire       hit_f2   = i_addr >= `DIM_OFS_FSEL2_1 && f2_idx < 3'd5
                          && i_addr < `DIM_OFS_POL1;
    wire       hit_pl   = i_addr >= `DIM_OFS_POL1 && pl_idx < 3'd5
                          && i_addr < `DIM_OFS_CTRL;
    // Thermistor code only on terminal 5.
    wire       ptc_bad_fs = i_wdata == `DIM_FN_PTC && fs_idx != 3'd4;
    wire       ptc_bad_f2 = i_wdata == `DIM_FN_PTC && f2_idx != 3'd4;
    // Refuse duplicate codes.
    // The helpers read the selector arrays, which a continuous assignment
    // would not wake up on, so they are evaluated inside a process.
    logic      fs_ok;
    logic      f2_ok;
    always_comb begin
        fs_ok = !code_taken(i_wdata, fs_idx, 1'b0) && !ptc_bad_fs;
        f2_ok = !code_taken(i_wdata, f2_idx, 1'b1) && !ptc_bad_f2;
    end
    wire       bank     = ctrl[0];

    // Two-stage synchroniser on the terminals. The stages carry no
    // reset: a contact level means something from the first edge on, and
    // clearing it would only hide a switch that is already closed.
    always_ff @(posedge i_clk_sys) begin
        sync1 <= i_term;
        sync2 <= sync1;
    end

    // Polarity applied with no latency beyond the synchroniser.
    logic [4:0] act;
    always_comb begin
        for (int k = 0; k < 5; k++) begin
            logic [7:0] code;
            code = sel_code(3'(k), bank);
            // Reset and thermistor ignore the polarity setting.
            if (code == `DIM_FN_FRST || code == `DIM_FN_PTC) begin
                act[k] = sync2[k];
            end else begin
                // Default high-active, takes effect at once.
                act[k] = (pol[k] == `DIM_POL_NC) ? !sync2[k] : sync2[k];
            end
        end
    end

    // Run and coast inputs by function code, codes 00, 01 and 0B.
    logic cw_on;
    logic ccw_on;
    logic coast_on;
    always_comb begin
        cw_on    = fn_on(`DIM_FN_CW, act, bank);
        ccw_on   = fn_on(`DIM_FN_CCW, act, bank);
        coast_on = fn_on(`DIM_FN_COAST, act, bank);
    end

    // Preset index bits, least significant at code 02. An index bit
    // with no terminal assigned simply reads as zero.
    logic [3:0] next_preset;
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            next_preset[b] = fn_on(8'(`DIM_FN_PRESET0 + b), act, bank);
        end
    end

    // Function decode. The levels are
    // registered together with the run command, so the core sees every
    // change of terminals in one and the same clock.
    dim_func_t next_func;
    always_comb begin
        next_func.jog                    = fn_on(`DIM_FN_JOG, act, bank);
        next_func.dc_braking             = fn_on(`DIM_FN_DCB, act, bank);
        next_func.second_set             = fn_on(`DIM_FN_SET2, act, bank);
        next_func.alt_ramp_select        = fn_on(`DIM_FN_RAMP2, act, bank);
        next_func.free_coast_inhibit     = coast_on;
        next_func.outside_fault_trip     = fn_on(`DIM_FN_EXTFLT, act, bank);
        next_func.power_on_start_guard   = fn_on(`DIM_FN_USP, act, bank);
        next_func.parameter_lock         = fn_on(`DIM_FN_LOCK, act, bank);
        next_func.analog_input_choose    = fn_on(`DIM_FN_AIN, act, bank);
        next_func.fault_reset            = fn_on(`DIM_FN_FRST, act, bank);
        next_func.thermistor_input       = fn_on(`DIM_FN_PTC, act, bank);
        next_func.three_wire_run_pulse   = fn_on(`DIM_FN_STA, act, bank);
        next_func.three_wire_halt        = fn_on(`DIM_FN_STP, act, bank);
        next_func.three_wire_dir         = fn_on(`DIM_FN_FR, act, bank);
        next_func.closed_loop_enable     = fn_on(`DIM_FN_PID, act, bank);
        next_func.integral_clear         = fn_on(`DIM_FN_INTEGRAL_CLEAR, act, bank);
        next_func.motor_pot_raise        = fn_on(`DIM_FN_UP, act, bank);
        next_func.motor_pot_lower        = fn_on(`DIM_FN_DWN, act, bank);
        next_func.motor_pot_zero         = fn_on(`DIM_FN_DWN0, act, bank);
        next_func.keypad_control_select  = fn_on(`DIM_FN_OPE, act, bank);
        next_func.freq_offset_add        = fn_on(`DIM_FN_ADD, act, bank);
        next_func.terminal_control_force = fn_on(`DIM_FN_FTM, act, bank);
        next_func.fast_response          = fn_on(`DIM_FN_RDY, act, bank);
        next_func.second_bank_special    = fn_on(`DIM_FN_SPSET, act, bank);
    end

    // Run state. Coast wins over everything so an emergency stop is never
    // softened into a ramp.
    wire conflict = cw_on && ccw_on;
    wire any_run  = cw_on || ccw_on;
    // The input that started the present run; its release ends the run
    // even when the other direction closes in the same clock.
    wire held_run = o_cmd.ccw ? ccw_on : cw_on;
    always_comb begin
        next_state = state;
        case (state)
            DIM_ST_STOP: begin
                // Both inputs from standstill: stay stopped.
                if (coast_on || conflict) begin
                    next_state = DIM_ST_STOP;
                // A run level present straight after reset starts.
                end else if (any_run && !i_keypad_stop) begin
                    next_state = DIM_ST_RUN;
                end
            end
            DIM_ST_DECEL: begin
                // A conflict during the ramp switches the output off.
                if (coast_on || conflict) begin
                    next_state = DIM_ST_COAST;
                // A held stop key keeps the ramp going and blocks restart.
                end else if (any_run && !i_keypad_stop) begin
                    next_state = DIM_ST_RUN;
                end
            end
            DIM_ST_RUN: begin
                if (coast_on || conflict) begin
                    next_state = DIM_ST_COAST;
                // Stop key or released run input: ramp.
                end else if (i_keypad_stop || !held_run) begin
                    next_state = DIM_ST_DECEL;
                end
            end
            DIM_ST_COAST: begin
                // Leave coast once the inhibit and conflict clear.
                if (!coast_on && !conflict) begin
                    next_state = any_run ? DIM_ST_RUN : DIM_ST_STOP;
                end
            end
            default: next_state = DIM_ST_STOP;
        endcase
    end

    // State and command outputs. The run, decel and coast bits are each a decode of the next
    // state, so the core never sees two of them high at once.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state        <= DIM_ST_STOP;
            o_cmd        <= '0;
            o_func       <= '0;
            o_preset_sel <= 4'h0;
            coast_prev   <= 1'b0;
        end else begin
            state          <= next_state;
            o_cmd.run      <= next_state == DIM_ST_RUN;
            o_cmd.decel    <= next_state == DIM_ST_DECEL;
            o_cmd.coast    <= next_state == DIM_ST_COAST;
            // Phase order: 0 is U-V-W, 1 is W-V-U. It is loaded on every
            // clock whose next state is run, so a ramp or coast keeps its rotation.
            if (next_state == DIM_ST_RUN) begin
                o_cmd.ccw <= ccw_on;
            end
            o_func       <= next_func;
            o_preset_sel <= next_preset;
            coast_prev   <= coast_on;
        end
    end

    // Restart mode and current-loop select outputs. The wait
    // pulse marks a coast release only when speed synchronisation is
    // chosen; a restart from 0 Hz needs no strobe. The core times the
    // restart wait itself, so no long counter lives here.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_current_loop_only <= 1'b0;
            o_restart_sync      <= 1'b0;
            o_restart_wait      <= 1'b0;
        end else begin
            o_current_loop_only <= next_func.analog_input_choose;
            o_restart_sync      <= ctrl[1];
            o_restart_wait      <= coast_prev && !coast_on && ctrl[1];
        end
    end

    // Write decode. A refused selector write leaves the old code in place
    // and only raises the status flag, so software can read back why.
    wire       we_fs    = hit_fs && fs_ok;
    wire       we_f2    = hit_f2 && f2_ok;
    wire       hit_ctrl = i_addr == `DIM_OFS_CTRL;
    // Duplicate or misplaced codes are refused.
    wire       refused  = (hit_fs && !fs_ok) || (hit_f2 && !f2_ok);

    // Selector storage in two sets, polarity, control.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            fsel[0] <= `DIM_RST_FSEL1;
            fsel[1] <= `DIM_RST_FSEL2;
            fsel[2] <= `DIM_RST_FSEL3;
            fsel[3] <= `DIM_RST_FSEL4;
            fsel[4] <= `DIM_RST_FSEL5;
            fsel2[0] <= `DIM_RST_FSEL1;
            fsel2[1] <= `DIM_RST_FSEL2;
            fsel2[2] <= `DIM_RST_FSEL3;
            fsel2[3] <= `DIM_RST_FSEL4;
            fsel2[4] <= `DIM_RST_FSEL5;
            for (int k = 0; k < 5; k++) begin
                pol[k] <= `DIM_RST_POL;
            end
            ctrl      <= 8'h00;
            wr_reject <= 1'b0;
        end else if (i_wr) begin
            wr_reject <= refused;
            if (we_fs) begin
                fsel[fs_idx] <= i_wdata;
            end
            if (we_f2) begin
                fsel2[f2_idx] <= i_wdata;
            end
            if (hit_pl) begin
                pol[pl_idx] <= {7'h00, i_wdata[0]};
            end
            if (hit_ctrl) begin
                ctrl <= {6'h00, i_wdata[1:0]};
            end
        end
    end

    // Read port: data stands one cycle after the strobe, zero otherwise.
    // Returning zero between reads keeps stale values off a shared bus
    // and lets a checker spot a strobe that was never given.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || !i_rd) begin
            o_rdata <= 8'h00;
        end else if (hit_fs) begin
            o_rdata <= fsel[fs_idx];
        end else if (hit_f2) begin
            o_rdata <= fsel2[f2_idx];
        end else if (hit_pl) begin
            o_rdata <= pol[pl_idx];
        end else if (i_addr == `DIM_OFS_CTRL) begin
            o_rdata <= ctrl;
        end else if (i_addr == `DIM_OFS_STATUS) begin
            o_rdata <= {wr_reject, 3'h0, state};
        end else if (i_addr == `DIM_OFS_FUNC_LO) begin
            o_rdata <= {3'h0, act};
        end else if (i_addr == `DIM_OFS_PRESET) begin
            o_rdata <= {4'h0, next_preset};
        end else begin
            o_rdata <= 8'h00;
        end
    end
endmodule

// File: tb/dim_mapper_properties.sv
`timescale 1ns/1ps
// Port-level checks of the terminal mapper, attached by bind.
module dim_mapper_props
    import dim_pkg::*;
#(
    parameter int NUM_IN = 5
) (
    input wire logic                i_clk_sys,
    input wire logic                i_rst,
    input wire logic [7:0]          i_addr,
    input wire logic [7:0]          i_wdata,
    input wire logic                i_wr,
    input wire logic                i_rd,
    input wire logic [7:0]          o_rdata,
    input wire dim_pkg::dim_cmd_t   o_cmd,
    input wire dim_pkg::dim_func_t  o_func,
    input wire logic                o_restart_sync,
    input wire logic                o_restart_wait
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    logic wb1;
    // Last restart-mode bit written, so the copy on the port can be judged.
    always_ff @(posedge i_clk_sys) begin
        if (i_wr && i_addr == 8'h18) begin
            wb1 <= i_wdata[1];
        end
    end
    AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    AST_RST_CLR: assert property ($past(i_rst) |-> o_cmd == 4'h0 &&
        o_func == '0) else $error("outputs not clear after reset");
    AST_COAST_OFF: assert property (o_cmd.coast |->
        !o_cmd.run && !o_cmd.decel) else $error("coast with drive on");
    AST_DIR_HOLD: assert property (o_cmd.run && $past(o_cmd.run) |->
        $stable(o_cmd.ccw)) else $error("direction flipped in run");
    AST_WAIT_PULSE: assert property (o_restart_wait |=> !o_restart_wait)
        else $error("restart wait longer than one cycle");
    AST_WAIT_SYNC: assert property (o_restart_wait |-> o_restart_sync)
        else $error("restart wait without sync mode");
    AST_CTRL_B1: assert property (i_wr && i_addr == 8'h18 ##1
        !(i_wr && i_addr == 8'h18) |-> ##1 o_restart_sync == wb1)
        else $error("restart mode output not following write");
    AST_STAT_HOT: assert property (i_rd && i_addr == 8'h19 |=>
        $onehot(o_rdata[3:0]) && o_rdata[6:4] == 3'h0)
        else $error("status state not one-hot");
    AST_POL_BIT: assert property (i_rd && i_addr >= 8'h10 &&
        i_addr <= 8'h14 |=> o_rdata[7:1] == 7'h00)
        else $error("polarity read has upper bits set");
    AST_UNMAP: assert property (i_rd && i_addr > 8'h1C |=>
        o_rdata == 8'h00) else $error("unmapped read not zero");
    COV_COAST: cover property (o_cmd.coast);
    COV_DECEL: cover property (o_cmd.decel);
    COV_WAIT: cover property (o_restart_wait);
endmodule

// File: tb/dim_switches.sv
`timescale 1ns/1ps
// Contacts on the five control terminals, closed to the supply when high.
module dim_switches (
    input  wire logic       i_pwr_ok,
    input  wire logic [4:0] i_close,
    output logic      [4:0] o_term
);
    // Contacts move at no fixed phase to the drive clock.
    // run contacts open before power.
    initial begin
        o_term = 5'h00;
        forever begin
            @(i_close or i_pwr_ok);
            o_term <= #1.3 (i_pwr_ok ? i_close : 5'h00);
        end
    end
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import dim_pkg::*;
    logic            clk, rst, kstop, bus_wr, bus_rd, pwr;
    logic      [7:0] addr, wdata, rdata;
    logic      [4:0] close, term;
    logic      [3:0] psel;
    logic            clo, rsync, rwait;
    dim_cmd_t        cmd;
    dim_func_t       func;
    int              mismatches, n_checks, pulses;
    logic      [7:0] rst_val [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h12};
    logic      [7:0] codes [25] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0B,
        8'h0C, 8'h0D, 8'h0F, 8'h10, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
        8'h17, 8'h18, 8'h1B, 8'h1C, 8'h1D, 8'h1F, 8'h32, 8'h33, 8'h34,
        8'h35, 8'hFF};
    int              bits [25] = '{23, 22, 21, 20, 19, 18, 17, 16, 15, 14,
        13, 12, 11, 10, 9, 8, 7, 6, 5, 4, 3, 2, 1, 0, 24};

    dim_mapper #(.NUM_IN(5)) dut_u (.i_clk_sys(clk), .i_rst(rst),
        .i_term(term), .i_keypad_stop(kstop), .i_addr(addr),
        .i_wdata(wdata), .i_wr(bus_wr), .i_rd(bus_rd), .o_rdata(rdata),
        .o_cmd(cmd), .o_func(func), .o_preset_sel(psel),
        .o_current_loop_only(clo), .o_restart_sync(rsync),
        .o_restart_wait(rwait));
    dim_switches sw_u (.i_pwr_ok(pwr), .i_close(close), .o_term(term));

    // A 4 ns clock, and a count of restart-wait pulses.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (rwait === 1'b1) pulses++;

    function automatic logic [7:0] cmdv();
        return {5'h00, cmd.run, cmd.decel, cmd.coast};
    endfunction
    task automatic chk8(input string nm, input logic [7:0] e, g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chkf(input logic [23:0] e);
        n_checks++;
        if (func !== e) begin
            mismatches++;
            $display("ERROR func exp %h got %h", e, func);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        bus_wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, e, m);
        @(posedge clk);
        bus_rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 chk8($sformatf("reg %h", a), e, rdata & m);
    endtask
    // Contacts and stop key change, then past the three-edge latency.
    task automatic drive(input logic [4:0] v, input logic k);
        @(posedge clk);
        close <= v;
        kstop <= k;
        repeat (5) @(posedge clk);
        #1;
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // A hang is cut short and reported as a failure.
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_sim();
    end

    initial begin
        {rst, pwr, kstop, bus_wr, bus_rd, addr, wdata, close} = '0;
        rst = 1'b1;
        mismatches = 0;
        n_checks = 0;
        pulses = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        pwr <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            rd(8'(k), rst_val[k], 8'hFF);
            rd(8'(k + 8), rst_val[k], 8'hFF);
            rd(8'(k + 16), 8'h00, 8'hFF);
        end
        rd(8'h18, 8'h00, 8'hFF);
        rd(8'h1F, 8'h00, 8'hFF);
        $display("test registers done");
        drive(5'b00100, 1'b0);
        chk8("preset", 8'h01, {4'h0, psel});
        drive(5'b01100, 1'b0);
        rd(8'h1C, 8'h03, 8'hFF);
        drive(5'b00001, 1'b0);
        chk8("cmd", 8'h04, cmdv());
        chk8("ccw", 8'h00, {7'h0, cmd.ccw});
        rd(8'h19, 8'h02, 8'h0F);
        drive(5'b00001, 1'b1);
        chk8("cmd", 8'h02, cmdv());
        drive(5'b00000, 1'b0);
        drive(5'b00010, 1'b0);
        chk8("cmd", 8'h04, cmdv());
        chk8("ccw", 8'h01, {7'h0, cmd.ccw});
        drive(5'b00011, 1'b0);
        chk8("cmd", 8'h01, cmdv());
        rd(8'h19, 8'h08, 8'h0F);
        drive(5'b00000, 1'b0);
        wr(8'h10, 8'h01);
        drive(5'b00000, 1'b0);
        chk8("cmd", 8'h04, cmdv());
        wr(8'h10, 8'h00);
        drive(5'b00000, 1'b0);
        chk8("cmd", 8'h02, cmdv());
        $display("test run commands done");
        wr(8'h01, 8'h00);
        rd(8'h19, 8'h80, 8'h80);
        rd(8'h01, 8'h01, 8'hFF);
        wr(8'h00, 8'h13);
        rd(8'h00, 8'h00, 8'hFF);
        wr(8'h04, 8'h13);
        rd(8'h04, 8'h13, 8'hFF);
        rd(8'h19, 8'h00, 8'h80);
        for (int k = 0; k < 25; k++) begin
            wr(8'h04, codes[k]);
            drive(5'h10, 1'b0);
            chkf(24'h1 << bits[k]);
            chk8("aloop", {7'h0, codes[k] == 8'h10}, {7'h0, clo});
            drive(5'h00, 1'b0);
            chkf(24'h0);
        end
        wr(8'h04, 8'h12);
        wr(8'h14, 8'h01);
        drive(5'h00, 1'b0);
        chkf(24'h0);
        wr(8'h04, 8'h06);
        drive(5'h00, 1'b0);
        chkf(24'h1 << 23);
        wr(8'h14, 8'h00);
        wr(8'h04, 8'h12);
        $display("test function codes done");
        wr(8'h18, 8'h01);
        wr(8'h08, 8'h17);
        drive(5'h01, 1'b0);
        chkf(24'h1 << 9);
        drive(5'h00, 1'b0);
        wr(8'h18, 8'h02);
        wr(8'h02, 8'h0B);
        drive(5'h04, 1'b0);
        chkf(24'h1 << 19);
        chk8("sync", 8'h01, {7'h0, rsync});
        pulses = 0;
        drive(5'h00, 1'b0);
        chk8("pulses", 8'h01, 8'(pulses));
        $display("test parameter sets and coast done");
        @(posedge clk);
        rst <= 1'b1;
        close <= 5'h01;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk8("cmd", 8'h04, cmdv());
        chk8("ccw", 8'h00, {7'h0, cmd.ccw});
        rd(8'h02, 8'h02, 8'hFF);
        $display("test reset with run input closed done");
        end_sim();
    end
endmodule

bind dim_mapper dim_mapper_props #(.NUM_IN(NUM_IN)) chk_u (.i_clk_sys,
    .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_cmd, .o_func,
    .o_restart_sync, .o_restart_wait);
